// ### bench/huff_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// shared unsafe line with pull-up
// ----------------------------------------
module huff_line_model (
  input wire logic pull_a,
  input wire logic pull_b,
  output logic line
);
  // any party pulling wins, else the pull-up gives high
  assign line = !(pull_a || pull_b);
endmodule : huff_line_model
`default_nettype wire

// ### bench/huff_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// unsafe flag checker
// ----------------------------------------
module huff_top_properties (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic WRITE_GATE,
  input wire logic FAULT_REF,
  input wire logic FAULT_LOW_SUPPLY,
  input wire logic FAULT_WDATA_SLOW,
  input wire logic FAULT_HEAD_OPEN,
  input wire logic FAULT_DRIVER_BIASED,
  input wire logic THERMAL_ASPERITY_DETECT,
  input wire logic UNSAFE_FLAG_OUT,
  input wire logic UNSAFE_FLAG_OE,
  input wire logic [3:0] HEAD_SELECT,
  input wire logic TA_ENABLE,
  input wire logic WRITE_INHIBIT,
  input wire logic WRITE_ACTIVE
);
  logic [7:0] quiet_r;
  logic [7:0] quiet_nxt;
  logic cause;
  // cycles since any possible unsafe cause in read mode
  assign cause = FAULT_REF | FAULT_LOW_SUPPLY | FAULT_WDATA_SLOW | FAULT_HEAD_OPEN
    | FAULT_DRIVER_BIASED | THERMAL_ASPERITY_DETECT | WRITE_ACTIVE | (HEAD_SELECT == 4'h0);
  assign quiet_nxt = cause ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};
  // quiet counter
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      quiet_r <= 8'h00;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence settle_s;
    UNSAFE_FLAG_OE [*3];
  endsequence
  sequence asperity_s;
    (TA_ENABLE && THERMAL_ASPERITY_DETECT) [*8];
  endsequence
  open_collector_a: assert property (UNSAFE_FLAG_OUT == 1'b0)
    else $error("flag data not low");
  read_head_a: assert property (!WRITE_ACTIVE |-> HEAD_SELECT <= 4'h9)
    else $error("bad head selected in read");
  inhibit_write_a: assert property (WRITE_INHIBIT |-> WRITE_ACTIVE)
    else $error("inhibit outside write");
  asperity_low_a: assert property (asperity_s |-> UNSAFE_FLAG_OE)
    else $error("asperity not flagged");
  write_entry_a: assert property ($rose(WRITE_ACTIVE) && !TA_ENABLE |=> settle_s)
    else $error("flag not low in settle");
  gate_read_a: assert property (!WRITE_GATE [*8] |-> !WRITE_ACTIVE)
    else $error("write without gate");
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read cycle");
  safe_release_a: assert property (quiet_r == 8'd200 |-> !UNSAFE_FLAG_OE)
    else $error("flag held past release time");
endmodule : huff_top_properties
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// testbench
// ----------------------------------------
module tb;
  logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, WRITE_GATE = 1'b0, oth = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic [5:0] flt = 6'h00;
  logic UNSAFE_FLAG_OUT, UNSAFE_FLAG_OE, WRITE_INHIBIT, TA_ENABLE, WRITE_ACTIVE, ln;
  logic [3:0] HEAD_SELECT;
  logic [1:0] TA_THRESHOLD;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1c};
  logic [27:0] rw [26];
  int miscompares = 0, checked = 0, cyc = 0, n;
  // clock and timeout
  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end
  huff_top dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .WRITE_GATE(WRITE_GATE), .FAULT_REF(flt[5]), .FAULT_LOW_SUPPLY(flt[4]),
    .FAULT_WDATA_SLOW(flt[3]), .FAULT_HEAD_OPEN(flt[2]), .FAULT_DRIVER_BIASED(flt[1]),
    .THERMAL_ASPERITY_DETECT(flt[0]), .UNSAFE_FLAG_IN(ln), .UNSAFE_FLAG_OUT(UNSAFE_FLAG_OUT),
    .UNSAFE_FLAG_OE(UNSAFE_FLAG_OE), .HEAD_SELECT(HEAD_SELECT), .TA_THRESHOLD(TA_THRESHOLD),
    .TA_ENABLE(TA_ENABLE), .WRITE_INHIBIT(WRITE_INHIBIT), .WRITE_ACTIVE(WRITE_ACTIVE));
  huff_line_model u_line (.pull_a(UNSAFE_FLAG_OE), .pull_b(oth), .line(ln));
  task automatic wt(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : wt
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    wt(1);
    WR <= 1'b0;
    wt(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ADDR <= a;
    RD <= 1'b1;
    wt(1);
    RD <= 1'b0;
    chk(RDATA, e);
    wt(1);
  endtask : rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // row: config, power, test, servo, head, gate, faults, expected {oe, inhibit}
  function automatic logic [27:0] r(input int c, p, t, s, h, g, f, e);
    return {c[7:0], p[1:0], t[2:0], s[1:0], h[3:0], g[0], f[5:0], e[1:0]};
  endfunction : r
  // main sequence
  initial begin
    rw = '{r(0,0,0,0,1,0,32,0), r(0,1,0,0,1,0,32,0), r(0,2,0,0,1,0,32,0),
      r(0,3,0,0,1,0,32,2), r(0,3,0,0,1,0,16,2), r(0,3,0,0,10,0,0,2), r(0,3,0,0,15,0,0,2),
      r(0,3,0,0,9,0,0,0), r(8,3,0,0,1,0,32,0), r(0,3,7,0,1,0,1,2), r(0,3,6,0,1,0,1,2),
      r(0,3,4,0,1,0,32,0), r(0,3,1,0,1,0,32,0), r(0,3,3,0,1,0,32,0), r(8,3,0,0,1,1,0,2),
      r(0,3,0,0,1,1,0,2), r(0,3,0,0,1,1,8,0), r(0,3,0,0,1,1,4,0), r(0,3,0,0,1,1,2,0),
      r(0,3,0,0,1,1,32,0), r(0,3,0,0,12,1,0,0), r(0,3,0,0,1,1,16,1), r(4,3,0,0,1,1,16,0),
      r(0,3,0,1,1,1,32,2), r(0,3,0,3,1,1,32,2), r(0,3,2,0,1,1,0,0)};
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    wt(1);
    foreach (rw[i]) begin
      WRITE_GATE <= rw[i][8];
      wt(10);
      wr(8'h00, rw[i][27:20]);
      wr(8'h04, {6'h00, rw[i][19:18]});
      wr(8'h08, {4'h0, rw[i][12:9]});
      wr(8'h14, {6'h00, rw[i][14:13]});
      wr(8'h18, {5'h00, rw[i][17:15]});
      flt <= rw[i][7:2];
      wt(20);
      chk(UNSAFE_FLAG_OE, rw[i][1]);
      chk(WRITE_INHIBIT, rw[i][0]);
      flt <= 6'h00;
      WRITE_GATE <= 1'b0;
      wr(8'h08, 8'h01);
      wt(130);
      wr(8'h18, 8'h00);
    end
    $display("mode table done");
    wr(8'h04, 8'h03);
    wr(8'h18, 8'h05);
    wr(8'h1c, 8'h04);
    chk(TA_THRESHOLD, 8'h03);
    chk(TA_ENABLE, 8'h01);
    wr(8'h1c, 8'h03);
    chk(TA_THRESHOLD, 8'h01);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h3c);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    wr(8'h18, 8'hf8);
    chk(TA_ENABLE, 8'h00);
    wr(8'h04, 8'h00);
    oth <= 1'b1;
    flt <= 6'h20;
    wt(10);
    chk(ln, 8'h00);
    chk(UNSAFE_FLAG_OE, 8'h00);
    oth <= 1'b0;
    flt <= 6'h00;
    wt(2);
    chk(ln, 8'h01);
    $display("register and line tests done");
    wr(8'h08, 8'h0c);
    chk(HEAD_SELECT, 8'h00);
    wr(8'h08, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h03);
    flt <= 6'h20;
    wt(20);
    flt <= 6'h00;
    wt(60);
    flt <= 6'h20;
    wt(10);
    flt <= 6'h00;
    n = 0;
    while (UNSAFE_FLAG_OE === 1'b1 && n < 300) begin
      wt(1);
      n++;
    end
    chk(n >= 100 && n <= 200, 8'h01);
    wt(220);
    wr(8'h00, 8'h3c);
    wr(8'h14, 8'h03);
    wr(8'h18, 8'h07);
    NRST <= 1'b0;
    wt(8);
    NRST <= 1'b1;
    wt(1);
    foreach (ra[i]) rd(ra[i], 8'h00);
    $display("hold and reset tests done");
    stop_test();
  end
endmodule : tb
bind huff_top huff_top_properties u_props (.CLK(CLK), .NRST(NRST), .RD(RD), .RDATA(RDATA),
  .WRITE_GATE(WRITE_GATE), .FAULT_REF(FAULT_REF), .FAULT_LOW_SUPPLY(FAULT_LOW_SUPPLY),
  .FAULT_WDATA_SLOW(FAULT_WDATA_SLOW), .FAULT_HEAD_OPEN(FAULT_HEAD_OPEN),
  .FAULT_DRIVER_BIASED(FAULT_DRIVER_BIASED), .THERMAL_ASPERITY_DETECT(THERMAL_ASPERITY_DETECT),
  .UNSAFE_FLAG_OUT(UNSAFE_FLAG_OUT), .UNSAFE_FLAG_OE(UNSAFE_FLAG_OE),
  .HEAD_SELECT(HEAD_SELECT), .TA_ENABLE(TA_ENABLE), .WRITE_INHIBIT(WRITE_INHIBIT),
  .WRITE_ACTIVE(WRITE_ACTIVE));
`default_nettype wire

// ### verilog/huff_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// constants and types of the unsafe flag block
// ----------------------------------------------------------------
package huff_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_POWER = 4'h1;
  localparam logic [3:0] IDX_HEAD = 4'h2;
  localparam logic [3:0] IDX_SERVO = 4'h5;
  localparam logic [3:0] IDX_TEST = 4'h6;
  localparam logic [3:0] IDX_COMP = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'hb;
  localparam logic [3:0] IDX_ID = 4'hf;

  // field positions
  localparam int CFG_INHIBIT_BIT = 2;
  localparam int CFG_MASK_BIT = 3;
  localparam int TEST_TAS_BIT = 2;
  localparam int COMP_THRESH_BIT = 2;
  localparam int TEST_THRESH_BIT = 0;

  // writable bits of each register; other positions are not stored
  localparam logic [7:0] CONFIG_BITS = 8'h3c;
  localparam logic [7:0] POWER_BITS = 8'h03;
  localparam logic [7:0] HEAD_BITS = 8'h0f;
  localparam logic [7:0] SERVO_BITS = 8'h03;
  localparam logic [7:0] TEST_BITS = 8'h07;
  localparam logic [7:0] COMP_BITS = 8'h07;

  // reset value, last valid head code and fallback head
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] HEAD_LAST_VALID = 4'h9;
  localparam logic [3:0] HEAD_DEFAULT = 4'h0;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SAFE_HOLD_NS = 500;
  localparam int WRITE_SETTLE_NS = 15;
  localparam int SAFE_HOLD_CYC = (SAFE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_SETTLE_CYC = (WRITE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // synchronised fault detector levels
  typedef struct packed {
    logic ref_bad;
    logic low_supply;
    logic wdata_slow;
    logic head_open;
    logic driver_biased;
    logic ta_detect;
  } huff_fault_t;

  // power state from the power control field
  typedef enum logic [1:0] {PM_SLEEP, PM_STANDBY, PM_ACTIVE} huff_pmode_t;

  // read / write sequencing
  typedef enum logic [1:0] {RW_READ, RW_SETTLE, RW_WRITE} huff_rw_t;

endpackage : huff_pkg
`default_nettype wire

// ### verilog/huff_top.sv
// Notes on behaviour
// RL1 - unassigned register bits are not stored and change nothing
// RL2 - every programmable register clears to zero at reset
// RL3 - asperity threshold code joins test register lsb and compensation bit 2
// RL4 - unsafe flag is open collector: pull low or release
// RL5 - sleep and standby release the flag whatever the mask
// RL6 - read mode with mask set releases the flag
// RL7 - read mode unmasked pulls low on bad head, reference fault, low supply
// RL8 - head codes 0 to 9 valid, 10 to 15 unsafe
// RL9 - test mode releases flag unless asperity detection on; asperity pulls low
// RL10 - servo write mode pulls the flag low always
// RL11 - write mode with mask set pulls the flag low
// RL12 - write mode unmasked releases the flag on any write fault
// RL13 - inhibit bit zero lets low supply cut write current; reporting unchanged
// RL14 - unsafe holds while fault present and for the hold time after
// RL15 - entering write forces flag low until the switching transient passes
// RL16 - open head detection aims at a few nanoseconds after settling
// RL17 - analog test in read or non-servo write releases the flag
// RL18 - power field: 00 sleep, one bit standby, 11 active
// RL19 - bad head code selects head zero in read, unsafe in write
// RL20 - test field msb set means asperity detection, middle bit ignored
// RL21 - fault inputs synchronised; hold counter restarts on every fault
`timescale 1ns/1ps
`default_nettype none

module huff_top #(
  parameter logic [3:0] DEVICE_ID = 4'h5 // arbitrary value
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic WRITE_GATE,
  input wire logic FAULT_REF,
  input wire logic FAULT_LOW_SUPPLY,
  input wire logic FAULT_WDATA_SLOW,
  input wire logic FAULT_HEAD_OPEN,
  input wire logic FAULT_DRIVER_BIASED,
  input wire logic THERMAL_ASPERITY_DETECT,
  input wire logic UNSAFE_FLAG_IN,
  output logic UNSAFE_FLAG_OUT,
  output logic UNSAFE_FLAG_OE,
  output logic [3:0] HEAD_SELECT,
  output logic [1:0] TA_THRESHOLD,
  output logic TA_ENABLE,
  output logic WRITE_INHIBIT,
  output logic WRITE_ACTIVE
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 8;
  localparam logic [7:0] HOLD_LOAD = 8'(huff_pkg::SAFE_HOLD_CYC);
  localparam logic [3:0] SETTLE_LOAD = 4'(huff_pkg::WRITE_SETTLE_CYC);

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;

  assign pin_raw = {UNSAFE_FLAG_IN, WRITE_GATE, FAULT_REF, FAULT_LOW_SUPPLY,
                    FAULT_WDATA_SLOW, FAULT_HEAD_OPEN, FAULT_DRIVER_BIASED,
                    THERMAL_ASPERITY_DETECT};

  // three synchroniser flops and a level flop per pin; level accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge CLK) begin // RL21
        if (!NRST) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          lvl_r <= (s2_r == s3_r) ? s3_r : lvl_r;
        end
      end
      assign pin_s[gi] = lvl_r;
    end
  endgenerate

  huff_pkg::huff_fault_t flt;
  logic line_level;
  logic write_req;

  assign flt = huff_pkg::huff_fault_t'(pin_s[5:0]);
  assign write_req = pin_s[6];
  assign line_level = pin_s[7];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [7:0] config_r;
  logic [7:0] power_r;
  logic [7:0] head_r;
  logic [7:0] servo_r;
  logic [7:0] test_r;
  logic [7:0] comp_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status_word;

  logic addr_ok;
  logic [3:0] idx;
  logic wr_config;
  logic wr_power;
  logic wr_head;
  logic wr_servo;
  logic wr_test;
  logic wr_comp;

  // word aligned decode of the low address space
  assign addr_ok = (ADDR[1:0] == 2'h0) && (ADDR[7:6] == 2'h0);
  assign idx = ADDR[5:2];
  assign wr_config = WR && addr_ok && (idx == huff_pkg::IDX_CONFIG);
  assign wr_power = WR && addr_ok && (idx == huff_pkg::IDX_POWER);
  assign wr_head = WR && addr_ok && (idx == huff_pkg::IDX_HEAD);
  assign wr_servo = WR && addr_ok && (idx == huff_pkg::IDX_SERVO);
  assign wr_test = WR && addr_ok && (idx == huff_pkg::IDX_TEST);
  assign wr_comp = WR && addr_ok && (idx == huff_pkg::IDX_COMP);

  // registers keep only their assigned bits, cleared at reset
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      config_r <= huff_pkg::REG_RESET; // RL2
      power_r <= huff_pkg::REG_RESET;
      head_r <= huff_pkg::REG_RESET;
      servo_r <= huff_pkg::REG_RESET;
      test_r <= huff_pkg::REG_RESET;
      comp_r <= huff_pkg::REG_RESET;
    end else begin
      if (wr_config) config_r <= WDATA & huff_pkg::CONFIG_BITS; // RL1
      if (wr_power) power_r <= WDATA & huff_pkg::POWER_BITS;
      if (wr_head) head_r <= WDATA & huff_pkg::HEAD_BITS;
      if (wr_servo) servo_r <= WDATA & huff_pkg::SERVO_BITS;
      if (wr_test) test_r <= WDATA & huff_pkg::TEST_BITS;
      if (wr_comp) comp_r <= WDATA & huff_pkg::COMP_BITS;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD && addr_ok) begin
      unique case (idx)
        huff_pkg::IDX_CONFIG: rdata_nxt = config_r;
        huff_pkg::IDX_POWER: rdata_nxt = power_r;
        huff_pkg::IDX_HEAD: rdata_nxt = head_r;
        huff_pkg::IDX_SERVO: rdata_nxt = servo_r;
        huff_pkg::IDX_TEST: rdata_nxt = test_r;
        huff_pkg::IDX_COMP: rdata_nxt = comp_r;
        huff_pkg::IDX_STATUS: rdata_nxt = status_word;
        huff_pkg::IDX_ID: rdata_nxt = {4'h0, DEVICE_ID};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  huff_pkg::huff_pmode_t pmode;
  logic active;
  logic mask_bit;
  logic inhibit_bit;
  logic head_bad;
  logic tas_mode;
  logic atest_mode;
  logic servo_mode;

  // power field: both clear sleep, both set active, else standby
  assign pmode = (power_r[1:0] == 2'h3) ? huff_pkg::PM_ACTIVE :
                 (power_r[1:0] == 2'h0) ? huff_pkg::PM_SLEEP :
                 huff_pkg::PM_STANDBY; // RL18
  assign active = (pmode == huff_pkg::PM_ACTIVE);
  assign mask_bit = config_r[huff_pkg::CFG_MASK_BIT];
  assign inhibit_bit = config_r[huff_pkg::CFG_INHIBIT_BIT];
  assign head_bad = (head_r[3:0] > huff_pkg::HEAD_LAST_VALID); // RL8
  assign tas_mode = test_r[huff_pkg::TEST_TAS_BIT]; // RL20
  assign atest_mode = !tas_mode && (test_r[1:0] != 2'h0);
  assign servo_mode = (servo_r[1:0] != 2'h0);

  // asperity threshold code and detector enable
  assign TA_THRESHOLD = {comp_r[huff_pkg::COMP_THRESH_BIT],
                         test_r[huff_pkg::TEST_THRESH_BIT]}; // RL3
  assign TA_ENABLE = active && tas_mode;

  // out of range code falls back to head zero while reading
  assign HEAD_SELECT = (head_bad && !WRITE_ACTIVE) ? huff_pkg::HEAD_DEFAULT
                                                   : head_r[3:0]; // RL19

  // ----------------------------------------------------------------
  // write entry sequencing
  // ----------------------------------------------------------------
  huff_pkg::huff_rw_t rw_r;
  huff_pkg::huff_rw_t rw_nxt;
  logic [3:0] settle_r;
  logic [3:0] settle_nxt;
  logic want_write;

  assign want_write = active && write_req;

  // write detection waits out the switching transient
  always_comb begin
    rw_nxt = rw_r;
    settle_nxt = settle_r;
    unique case (rw_r)
      huff_pkg::RW_READ: begin
        if (want_write) begin
          rw_nxt = huff_pkg::RW_SETTLE; // RL15
          settle_nxt = SETTLE_LOAD;
        end
      end
      huff_pkg::RW_SETTLE: begin
        if (!want_write) begin
          rw_nxt = huff_pkg::RW_READ;
          settle_nxt = 4'h0;
        end else if (settle_r <= 4'h1) begin
          rw_nxt = huff_pkg::RW_WRITE; // RL16
          settle_nxt = 4'h0;
        end else begin
          settle_nxt = settle_r - 4'h1;
        end
      end
      huff_pkg::RW_WRITE: begin
        if (!want_write) rw_nxt = huff_pkg::RW_READ;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rw_r <= huff_pkg::RW_READ;
      settle_r <= 4'h0;
    end else begin
      rw_r <= rw_nxt;
      settle_r <= settle_nxt;
    end
  end

  assign WRITE_ACTIVE = (rw_r != huff_pkg::RW_READ);

  // ----------------------------------------------------------------
  // fault merge and safe release timer
  // ----------------------------------------------------------------
  logic read_fault;
  logic write_fault;
  logic fault_now;
  logic fault_held;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;

  assign read_fault = head_bad || flt.ref_bad || flt.low_supply; // RL7
  assign write_fault = read_fault || flt.wdata_slow || flt.head_open ||
                       flt.driver_biased; // RL12
  assign fault_now = (rw_r == huff_pkg::RW_WRITE) ? write_fault :
                     (rw_r == huff_pkg::RW_READ) ? read_fault : 1'b0;

  // counter reloads on every fault, counts down once all are gone
  assign hold_nxt = fault_now ? HOLD_LOAD :
                    (hold_r != 8'h00) ? hold_r - 8'h01 : 8'h00; // RL21
  assign fault_held = fault_now || (hold_r != 8'h00); // RL14

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      hold_r <= 8'h00;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // low supply cuts write current only when inhibit bit is clear
  assign WRITE_INHIBIT = WRITE_ACTIVE && flt.low_supply && !inhibit_bit; // RL13

  // ----------------------------------------------------------------
  // open collector driver
  // ----------------------------------------------------------------
  logic pull_nxt;
  logic pull_r;

  // decides whether the shared line is pulled low
  always_comb begin
    pull_nxt = 1'b0;
    if (!active) begin
      pull_nxt = 1'b0; // RL5
    end else if (WRITE_ACTIVE && servo_mode) begin
      pull_nxt = 1'b1; // RL10
    end else if (atest_mode) begin
      pull_nxt = 1'b0; // RL17
    end else if (tas_mode) begin
      pull_nxt = flt.ta_detect; // RL9
    end else if (rw_r == huff_pkg::RW_SETTLE) begin
      pull_nxt = 1'b1; // RL15
    end else if (WRITE_ACTIVE) begin
      pull_nxt = mask_bit ? 1'b1 : !fault_held; // RL11 RL12
    end else begin
      pull_nxt = mask_bit ? 1'b0 : fault_held; // RL6 RL7
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pull_r <= 1'b0;
    end else begin
      pull_r <= pull_nxt;
    end
  end

  // only ever drives low; release leaves the line to the pull-up
  assign UNSAFE_FLAG_OUT = 1'b0; // RL4
  assign UNSAFE_FLAG_OE = pull_r; // RL4

  // status: line level, own pull, held fault, write state, raw faults
  assign status_word = {line_level, pull_r, fault_held, WRITE_ACTIVE,
                        flt.low_supply, flt.ref_bad, head_bad, flt.ta_detect};

endmodule : huff_top
`default_nettype wire
